/* File: include/nvm_test_regs.svh */
`ifndef NVM_TEST_REGS_SVH
`define NVM_TEST_REGS_SVH

// Clock rate in kHz and settle time in ns.
`define NVM_CLK_KHZ 100000
`define NVM_SETTLE_NS 10000
// Settle cycles, rounded up: ns * kHz / 1e6.
`define NVM_SETTLE_CYC ((`NVM_SETTLE_NS * `NVM_CLK_KHZ + 999999) / 1000000)
// Cycles between address set-up and sampling the data pins.
`define NVM_READ_CYC 4
// Idle levels of the fixed read-path pins.
`define NVM_PROG_IDLE 1'b0
`define NVM_BLOCK_IDLE 1'b0
`define NVM_LOAD_IDLE 1'b1

`endif

/* File: include/nvm_test_pkg.sv */
package nvm_test_pkg;

  // Requested operating mode of the macro.
  typedef enum logic [2:0] {
    MODE_STANDBY = 3'b000,
    MODE_READ = 3'b001,
    MODE_MARGIN_ERASED = 3'b010,
    MODE_MARGIN_WRITTEN = 3'b011,
    MODE_CELL_TEST = 3'b100
  } mode_type;

  // Static control levels presented to the macro.
  typedef struct packed {
    logic chipEnable;
    logic readEn;
    logic outputEnable;
    logic marginEnable;
    logic cellTestEnable;
    logic programSelect;
    logic blockSel;
    logic loadBar;
  } ctrl_type;

  // Digital control of the margin current source on the tester side.
  typedef enum logic [1:0] {
    BIAS_OFF = 2'b00,
    BIAS_SOURCE = 2'b01,
    BIAS_SINK = 2'b10,
    BIAS_SUPPLY = 2'b11
  } bias_type;

endpackage : nvm_test_pkg

/* File: core/nvm_ctrl_decode.sv */
`timescale 1ns/1ps
`include "nvm_test_regs.svh"

// Maps a mode onto the control pin levels and margin bias setting.
module nvm_ctrl_decode
  import nvm_test_pkg::*;
(
  input wire mode_type mode,
  output ctrl_type ctrl,
  output bias_type bias
);

  // Read-path decode; program pins stay at their read levels.
  always_comb begin
    ctrl = '0;
    bias = BIAS_OFF;
    // R1: read pin levels
    ctrl.programSelect = `NVM_PROG_IDLE;
    ctrl.blockSel = `NVM_BLOCK_IDLE;
    ctrl.loadBar = `NVM_LOAD_IDLE;
    case (mode)
      // R9: standby levels
      MODE_STANDBY: begin
        bias = BIAS_OFF;
      end
      // R10: normal read
      MODE_READ: begin
        ctrl.chipEnable = 1'b1;
        ctrl.readEn = 1'b1;
        ctrl.outputEnable = 1'b1;
      end
      // R3: erased margin levels
      MODE_MARGIN_ERASED: begin
        ctrl.chipEnable = 1'b1;
        ctrl.readEn = 1'b1;
        ctrl.outputEnable = 1'b1;
        ctrl.marginEnable = 1'b1;
        bias = BIAS_SOURCE;
      end
      // R4: written margin sinks
      MODE_MARGIN_WRITTEN: begin
        ctrl.chipEnable = 1'b1;
        ctrl.readEn = 1'b1;
        ctrl.outputEnable = 1'b1;
        ctrl.marginEnable = 1'b1;
        bias = BIAS_SINK;
      end
      // R7: cell test levels
      MODE_CELL_TEST: begin
        ctrl.chipEnable = 1'b1;
        ctrl.readEn = 1'b1;
        ctrl.marginEnable = 1'b1;
        ctrl.cellTestEnable = 1'b1;
        // R6: driver off, supply
        ctrl.outputEnable = 1'b0;
        bias = BIAS_SUPPLY;
      end
      default: begin
        bias = BIAS_OFF;
      end
    endcase
  end

endmodule : nvm_ctrl_decode

/* File: core/nvm_margin_test_ctrl.sv */
`timescale 1ns/1ps
`include "nvm_test_regs.svh"

// Behaviour
// R1: read modes hold program_select 0, block 0, load_bar 1.
// R2: margin entered only by raising margin_enable while already reading.
// R3: erased margin: all enables 1 but cell test 0; output 0 passes.
// R4: written margin: same levels, current sunk; output 1 passes.
// R5: macro closes analog switch to data pin when cell test raised.
// R6: cell test keeps output_enable low and margin input at supply.
// R7: cell test: enables 1, output_enable 0; data pin carries current.
// R8: wait at least 10 us after changing margin current before reading.
// R9: all enables 0 gives standby with data pins high impedance.
// R10: enables 1 with margin and cell test 0 gives normal read.
module nvm_margin_test_ctrl
  import nvm_test_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8,
  parameter int SETTLE_CYC = `NVM_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reqValid,
  input wire mode_type reqMode,
  input wire logic [ADDR_W-1:0] reqAddr,
  output logic reqReady,
  output logic rspValid,
  output logic [DATA_W-1:0] rspData,
  output logic [DATA_W-1:0] rspPass,
  input wire logic [DATA_W-1:0] dataIn,
  output ctrl_type pinCtrl,
  output bias_type pinBias,
  output logic [ADDR_W-1:0] pinAddr
);

  // Refuse widths and counts that the logic cannot serve.
  if (ADDR_W < 1 || DATA_W < 1 || SETTLE_CYC < 1) begin : g_bad_param
    $error("nvm_margin_test_ctrl: bad parameter");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ENTER = 3'b001,
    ST_SETTLE = 3'b010,
    ST_ACCESS = 3'b011,
    ST_DONE = 3'b100
  } state_type;

  localparam int CNT_W = $clog2(SETTLE_CYC + `NVM_READ_CYC + 1);

  state_type state_ff;
  mode_type mode_ff;
  mode_type stepMode;
  bias_type lastBias_ff;
  ctrl_type stepCtrl;
  bias_type stepBias;
  logic [CNT_W-1:0] cnt_ff;
  logic [DATA_W-1:0] sync1_ff;
  logic [DATA_W-1:0] sync2_ff;
  logic [DATA_W-1:0] sync3_ff;
  logic [DATA_W-1:0] stable_ff;

  // Margin modes pass through plain read first, so margin is raised in read.
  always_comb begin
    // R2: read before margin
    if (state_ff == ST_ENTER && mode_ff != MODE_STANDBY) begin
      stepMode = MODE_READ;
    end else if (state_ff == ST_IDLE) begin
      stepMode = MODE_STANDBY;
    end else begin
      stepMode = mode_ff;
    end
  end

  nvm_ctrl_decode u_decode (
    .mode(stepMode),
    .ctrl(stepCtrl),
    .bias(stepBias)
  );

  // Sequencer for one mode access.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      mode_ff <= MODE_STANDBY;
      cnt_ff <= '0;
      lastBias_ff <= BIAS_OFF;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (reqValid) begin
            mode_ff <= reqMode;
            state_ff <= ST_ENTER;
          end
        end
        ST_ENTER: begin
          state_ff <= ST_SETTLE;
          cnt_ff <= '0;
        end
        ST_SETTLE: begin
          // R8: bias settle wait
          if (stepBias != BIAS_OFF && stepBias != lastBias_ff &&
              cnt_ff < CNT_W'(SETTLE_CYC - 1)) begin
            cnt_ff <= cnt_ff + 1'b1;
          end else begin
            // Tracks the held bias pin, which ignores the off setting.
            if (stepBias != BIAS_OFF) begin
              lastBias_ff <= stepBias;
            end
            cnt_ff <= '0;
            state_ff <= ST_ACCESS;
          end
        end
        ST_ACCESS: begin
          if (cnt_ff < CNT_W'(`NVM_READ_CYC - 1)) begin
            cnt_ff <= cnt_ff + 1'b1;
          end else begin
            state_ff <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Registered pin drive; standby between accesses.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pinCtrl <= '{programSelect: `NVM_PROG_IDLE, blockSel: `NVM_BLOCK_IDLE,
                   loadBar: `NVM_LOAD_IDLE, default: 1'b0};
      pinBias <= BIAS_OFF;
      pinAddr <= '0;
    end else begin
      pinCtrl <= stepCtrl;
      // R8: hold bias between accesses
      // The margin current is unused outside margin and cell test, so the
      // last setting is kept there and only a real change costs a settle.
      if (stepBias != BIAS_OFF) begin
        pinBias <= stepBias;
      end
      if (state_ff == ST_IDLE && reqValid) begin
        pinAddr <= reqAddr;
      end
    end
  end

  // Three-stage synchroniser on the data pins; change taken when 2 and 3 agree.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
      stable_ff <= '0;
    end else begin
      sync1_ff <= dataIn;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      if (sync2_ff == sync3_ff) begin
        stable_ff <= sync3_ff;
      end
    end
  end

  // Answer and pass flags per bit.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rspValid <= 1'b0;
      rspData <= '0;
      rspPass <= '0;
      reqReady <= 1'b0;
    end else begin
      reqReady <= (state_ff == ST_IDLE) && !reqValid;
      rspValid <= (state_ff == ST_DONE);
      if (state_ff == ST_DONE) begin
        rspData <= stable_ff;
        case (mode_ff)
          // R3: zero passes
          MODE_MARGIN_ERASED: rspPass <= ~stable_ff;
          // R4: one passes
          MODE_MARGIN_WRITTEN: rspPass <= stable_ff;
          default: rspPass <= '0;
        endcase
      end
    end
  end

endmodule : nvm_margin_test_ctrl

/* File: sim/nvm_macro_model.sv */
`timescale 1ns/1ps
// Macro stand-in: the stored byte is the address xor 5a.
module nvm_macro_model
  import nvm_test_pkg::*;
(
  input wire logic clk,
  input wire ctrl_type pinCtrl,
  input wire logic [7:0] pinAddr,
  output logic [7:0] dataIn
);
  logic [7:0] lastOut_ff = 8'h00;
  logic drive;
  assign drive = pinCtrl.chipEnable & pinCtrl.readEn & pinCtrl.outputEnable;
  assign dataIn = drive ? (pinAddr ^ 8'h5a) : ~lastOut_ff;
  // Remembers the pin level so a released pin never holds it.
  always @(posedge clk) begin
    lastOut_ff <= dataIn;
  end
endmodule : nvm_macro_model

/* File: sim/nvm_margin_test_ctrl_chk.sv */
`timescale 1ns/1ps
`include "nvm_test_regs.svh"
// Watches the pin levels and answers of the controller.
module nvm_margin_test_ctrl_chk
  import nvm_test_pkg::*;
#(
  parameter int SETTLE_CYC = `NVM_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reqReady,
  input wire logic rspValid,
  input wire ctrl_type pinCtrl,
  input wire bias_type pinBias
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // The answer trails the sampled pins by the three synchroniser stages.
  localparam int ANSWER_LAG = 3;
  int biasAge_ff;
  bias_type prevBias_ff;
  // Counts cycles since the margin current setting last moved.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      biasAge_ff <= SETTLE_CYC + ANSWER_LAG;
      prevBias_ff <= BIAS_OFF;
    end else begin
      prevBias_ff <= pinBias;
      if (pinBias != prevBias_ff) begin
        biasAge_ff <= 0;
      end else if (biasAge_ff < SETTLE_CYC + ANSWER_LAG) begin
        biasAge_ff <= biasAge_ff + 1;
      end
    end
  end
  sequence testLevels;
    pinCtrl.chipEnable && pinCtrl.readEn && pinCtrl.marginEnable;
  endsequence
  a_read_fixed_pins: assert property (pinCtrl.readEn |->
    !pinCtrl.programSelect && !pinCtrl.blockSel && pinCtrl.loadBar)
    else $error("fixed pins wrong in read");
  a_margin_after_read: assert property ($rose(pinCtrl.marginEnable)
    |-> $past(pinCtrl.readEn)) else $error("margin not entered from read");
  a_margin_bias: assert property (pinCtrl.marginEnable &&
    pinCtrl.outputEnable |-> pinBias inside {BIAS_SOURCE, BIAS_SINK})
    else $error("margin bias wrong");
  a_cell_test_bias: assert property (pinCtrl.cellTestEnable |->
    !pinCtrl.outputEnable && pinBias == BIAS_SUPPLY)
    else $error("cell test bias or output enable wrong");
  a_cell_test_levels: assert property (pinCtrl.cellTestEnable |->
    testLevels) else $error("cell test levels wrong");
  a_bias_settle: assert property ($changed(pinBias) &&
    pinBias != BIAS_OFF |-> !rspValid [*3]) else $error("no settle");
  a_idle_standby: assert property (reqReady |->
    !pinCtrl.chipEnable && !pinCtrl.readEn) else $error("idle not standby");
  a_read_enables: assert property (pinCtrl.outputEnable |->
    pinCtrl.chipEnable && pinCtrl.readEn) else $error("read levels wrong");
  a_settle_age: assert property (rspValid |->
    biasAge_ff >= SETTLE_CYC + ANSWER_LAG)
    else $error("read taken before bias settled");
endmodule : nvm_margin_test_ctrl_chk
bind nvm_margin_test_ctrl nvm_margin_test_ctrl_chk
  #(.SETTLE_CYC(SETTLE_CYC)) nvm_margin_test_ctrl_chk_i (
  .clk(clk), .rst_b(rst_b), .reqReady(reqReady), .rspValid(rspValid),
  .pinCtrl(pinCtrl), .pinBias(pinBias));

/* File: sim/nvm_margin_test_ctrl_tb.sv */
`timescale 1ns/1ps
// Runs every mode through the controller against the macro stand-in.
module nvm_margin_test_ctrl_tb
  import nvm_test_pkg::*;
;
  localparam int SETTLE = 3;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic reqValid = 1'b0;
  mode_type reqMode = MODE_STANDBY;
  logic [7:0] reqAddr = 8'h00;
  logic reqReady, rspValid;
  logic [7:0] rspData, rspPass, dataIn, pinAddr;
  ctrl_type pinCtrl;
  bias_type pinBias;
  int num_errors = 0;
  int num_checks = 0;
  nvm_margin_test_ctrl #(.SETTLE_CYC(SETTLE)) nvm_margin_test_ctrl_i (
    .clk(clk), .rst_b(rst_b), .reqValid(reqValid), .reqMode(reqMode),
    .reqAddr(reqAddr), .reqReady(reqReady), .rspValid(rspValid),
    .rspData(rspData), .rspPass(rspPass), .dataIn(dataIn),
    .pinCtrl(pinCtrl), .pinBias(pinBias), .pinAddr(pinAddr));
  nvm_macro_model nvm_macro_model_i (.clk(clk), .pinCtrl(pinCtrl),
    .pinAddr(pinAddr), .dataIn(dataIn));
  // The clock toggles every half period.
  always #5 clk = ~clk;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("Checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  task automatic timeout();
    num_errors++;
    $display("Error at %0t: wait ran out", $time);
    give_verdict();
  endtask : timeout
  // Issues one request and counts cycles until its answer.
  task automatic access(input mode_type m, input logic [7:0] a,
                        output int cyc);
    for (cyc = 0; reqReady !== 1'b1; cyc++) begin
      if (cyc > 50) timeout();
      @(negedge clk);
    end
    reqMode = m;
    reqAddr = a;
    reqValid = 1'b1;
    @(negedge clk);
    reqValid = 1'b0;
    for (cyc = 1; rspValid !== 1'b1; cyc++) begin
      if (cyc > 2000) timeout();
      @(negedge clk);
    end
  endtask : access
  task automatic t_reset();
    check(pinCtrl, 8'h01);
    check({6'h00, pinBias}, 8'h00);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_modes();
    int cyc;
    logic [7:0] a;
    logic [7:0] exp;
    for (int m = 0; m < 5; m++) begin
      a = 8'h30 + 8'(m);
      access(mode_type'(m), a, cyc);
      exp = (m == 2) ? ~(a ^ 8'h5a) : (m == 3) ? (a ^ 8'h5a) : 8'h00;
      check(rspPass, exp);
      if (m > 0 && m < 4) check(rspData, a ^ 8'h5a);
    end
    $display("t_modes done");
  endtask : t_modes
  task automatic t_settle();
    int c1;
    int c2;
    access(MODE_MARGIN_WRITTEN, 8'h77, c1);
    access(MODE_MARGIN_WRITTEN, 8'h78, c2);
    check(8'(c1 - c2), 8'(SETTLE - 1));
    $display("t_settle done");
  endtask : t_settle
  // Holds reset for 16 cycles, then runs the scenarios.
  initial begin
    repeat (16) @(negedge clk);
    t_reset();
    rst_b = 1'b1;
    t_modes();
    t_settle();
    give_verdict();
  end
endmodule : nvm_margin_test_ctrl_tb
